// >>> logic/soft_reset_pkg.sv
// constants for the soft reset and strap latch sequencer
package soft_reset_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned RESET_HOLD_NS   = 500;
  localparam int unsigned OE_OFF_NS       = 1700;
  // least times, rounded up to whole cycles
  localparam int unsigned RESET_HOLD_CYC  = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OE_OFF_CYC      = (OE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 6;
  localparam int unsigned ADDR_W          = 5;
  localparam int unsigned MODE_W          = 8;
  localparam int unsigned SPEED_BIT       = 3;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_HOLD    = 2'b01,
    ST_OE_WAIT = 2'b11
  } seq_state_type;
endpackage

// >>> logic/phy_soft_reset_strap_latch.sv
// soft reset sequencer with strap latch and address pin driver control
//
// Function
// - A write of the upper control byte over the management link starts the soft reset.
// - The soft reset stays asserted for 500ns, then releases on a clock edge.
// - At that release all mode pins and address strap pins are captured.
// - Address pin drivers stay off from reset start until 1700ns after it.
// - After the strap window, address bit 3 drives out the 100 Mb/s indication.
// - Low power plus 100 Mb/s removes power from the 10 Mb/s and negotiation parts.
// - Five latched address bits pick one of 32 management addresses.
`timescale 1ns/10ps
`default_nettype none

module phy_soft_reset_strap_latch (
  input  wire logic                              core_clk,           // device clock
  input  wire logic                              reset_n,            // sync reset, active low
  input  wire logic                              ctrl_hi_byte_wr,    // upper control byte written
  input  wire logic [soft_reset_pkg::MODE_W-1:0] mode_pin_in,        // mode configuration pins
  input  wire logic [soft_reset_pkg::ADDR_W-1:0] phy_address_strap,  // address strap pin levels
  input  wire logic                              speed_100,          // 100 Mb/s operation
  input  wire logic                              low_power_in,       // low power pin
  input  wire logic [soft_reset_pkg::ADDR_W-1:0] mgmt_frame_addr,    // address of a mgmt frame
  output logic                                   soft_reset,         // internal reset, high
  output logic [soft_reset_pkg::MODE_W-1:0]      mode_cfg,           // latched mode straps
  output logic [soft_reset_pkg::ADDR_W-1:0]      phy_address,        // latched address
  output logic                                   address_pin_oe,     // address pin driver on
  output logic [soft_reset_pkg::ADDR_W-1:0]      address_pin_out,    // address pin drive value
  output logic                                   addr_match,         // frame is for this device
  output logic                                   ten_power_off,      // 10 Mb/s section off
  output logic                                   aneg_power_off      // negotiation circuit off
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [soft_reset_pkg::MODE_W-1:0] mode_meta_reg;
  logic [soft_reset_pkg::MODE_W-1:0] mode_sync_reg;
  logic [soft_reset_pkg::ADDR_W-1:0] addr_meta_reg;
  logic [soft_reset_pkg::ADDR_W-1:0] addr_sync_reg;
  logic                              lp_meta_reg;
  logic                              lp_sync_reg;

  always_ff @(posedge core_clk)
  begin
    mode_meta_reg <= mode_pin_in;
    mode_sync_reg <= mode_meta_reg;
    addr_meta_reg <= phy_address_strap;
    addr_sync_reg <= addr_meta_reg;
    lp_meta_reg   <= low_power_in;
    lp_sync_reg   <= lp_meta_reg;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // counter step, wraps at the counter width
  function automatic logic [soft_reset_pkg::CNT_W-1:0] cnt_inc(
    input logic [soft_reset_pkg::CNT_W-1:0] value
  );
    return value + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  soft_reset_pkg::seq_state_type     state_reg;
  soft_reset_pkg::seq_state_type     state_next;
  logic [soft_reset_pkg::CNT_W-1:0]  cnt_reg;
  logic [soft_reset_pkg::CNT_W-1:0]  cnt_next;

  localparam logic [soft_reset_pkg::CNT_W-1:0] HOLD_LAST =
    soft_reset_pkg::CNT_W'(soft_reset_pkg::RESET_HOLD_CYC - 1);
  localparam logic [soft_reset_pkg::CNT_W-1:0] OE_LAST =
    soft_reset_pkg::CNT_W'(soft_reset_pkg::OE_OFF_CYC - 1);

  wire hold_done = (state_reg == soft_reset_pkg::ST_HOLD) && (cnt_reg == HOLD_LAST);
  wire oe_done   = (state_reg == soft_reset_pkg::ST_OE_WAIT) && (cnt_reg == OE_LAST);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      soft_reset_pkg::ST_IDLE:
      begin
        if (ctrl_hi_byte_wr)
        begin
          state_next = soft_reset_pkg::ST_HOLD;
          cnt_next   = '0;
        end
      end
      soft_reset_pkg::ST_HOLD:
      begin
        cnt_next = cnt_inc(cnt_reg);
        if (hold_done)
          state_next = soft_reset_pkg::ST_OE_WAIT;
      end
      soft_reset_pkg::ST_OE_WAIT:
      begin
        cnt_next = cnt_inc(cnt_reg);
        if (oe_done)
          state_next = soft_reset_pkg::ST_IDLE;
        else if (ctrl_hi_byte_wr)
        begin
          state_next = soft_reset_pkg::ST_HOLD;
          cnt_next   = '0;
        end
      end
      default:
      begin
        state_next = soft_reset_pkg::ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= soft_reset_pkg::ST_IDLE;
      cnt_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire reset_on_next = (state_next == soft_reset_pkg::ST_HOLD);
  wire oe_on_next    = (state_next == soft_reset_pkg::ST_IDLE);
  wire speed_lp      = lp_sync_reg && speed_100;
  wire oe_next       = oe_on_next && !reset_on_next;
  wire match_next    = (mgmt_frame_addr == phy_address) && !soft_reset;
  wire power_next    = speed_lp && !soft_reset;

  // only the speed bit is driven high, the rest drive low
  logic [soft_reset_pkg::ADDR_W-1:0] pin_out_next;
  assign pin_out_next = soft_reset_pkg::ADDR_W'(speed_100) << soft_reset_pkg::SPEED_BIT;

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // reset held to rest of device
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      soft_reset <= 1'b0;
    else
      soft_reset <= reset_on_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      mode_cfg    <= soft_reset_pkg::MODE_RESET;
      phy_address <= soft_reset_pkg::ADDR_RESET;
    end
    else if (hold_done)
    begin
      mode_cfg    <= mode_sync_reg;
      phy_address <= addr_sync_reg;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      address_pin_oe <= 1'b0;
    else
      address_pin_oe <= oe_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      address_pin_out <= '0;
    else
      address_pin_out <= pin_out_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      addr_match <= 1'b0;
    else
      addr_match <= match_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ten_power_off  <= 1'b0;
      aneg_power_off <= 1'b0;
    end
    else
    begin
      ten_power_off  <= power_next;
      aneg_power_off <= power_next;
    end
  end

endmodule // phy_soft_reset_strap_latch

`default_nettype wire

// >>> tb/soft_reset_checker.sv
// assertions on the soft reset sequencer ports
`timescale 1ns/10ps
`default_nettype none
module soft_reset_checker (
  input wire logic       core_clk, reset_n, ctrl_hi_byte_wr, speed_100, low_power_in, // in
  input wire logic [7:0] mode_pin_in, mode_cfg,                                       // mode
  input wire logic [4:0] phy_address_strap, mgmt_frame_addr, phy_address,             // addr
  input wire logic [4:0] address_pin_out,                                             // pins
  input wire logic       soft_reset, address_pin_oe, addr_match,                      // out
  input wire logic       ten_power_off, aneg_power_off                                // power
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // run lengths counted in helper logic, not by repetition
  localparam logic [7:0] HOLD_CYC   = 8'h0d;
  localparam logic [7:0] OE_OFF_CYC = 8'h2b;
  logic [7:0] hi_cnt;
  logic [7:0] oe_low_cnt;
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      hi_cnt     <= 8'h00;
      oe_low_cnt <= 8'h00;
    end
    else
    begin
      hi_cnt     <= soft_reset ? hi_cnt + 8'h01 : 8'h00;
      oe_low_cnt <= !address_pin_oe ? oe_low_cnt + 8'h01 : 8'h00;
    end
  end
  chk_write_start: assert property (
    ctrl_hi_byte_wr && !soft_reset |=> soft_reset) else $error("write did not reset");
  chk_hold_len: assert property (
    $fell(soft_reset) |-> hi_cnt == HOLD_CYC) else $error("hold length");
  chk_hold_max: assert property (
    soft_reset |-> hi_cnt < HOLD_CYC) else $error("hold too long");
  chk_strap_take: assert property (
    $fell(soft_reset) |-> phy_address == $past(phy_address_strap, 3)
      && mode_cfg == $past(mode_pin_in, 3)) else $error("strap latch");
  chk_oe_window: assert property (
    $rose(soft_reset) |-> !address_pin_oe ##42 !address_pin_oe ##1 address_pin_oe)
    else $error("driver window");
  chk_oe_low_run: assert property (
    !address_pin_oe |-> oe_low_cnt < OE_OFF_CYC) else $error("driver off too long");
  chk_speed_out: assert property (
    address_pin_oe && $past(address_pin_oe) |-> address_pin_out == {1'b0, $past(speed_100),
      3'h0}) else $error("speed pin");
  chk_power_on: assert property (
    (low_power_in && speed_100 && !soft_reset)[*5] |=> ten_power_off && aneg_power_off)
    else $error("power not off");
  chk_power_back: assert property (
    (!low_power_in)[*5] |=> !ten_power_off && !aneg_power_off) else $error("power not on");
  chk_addr_match: assert property (
    $past(reset_n) |-> addr_match == ($past(mgmt_frame_addr) == $past(phy_address)
      && !$past(soft_reset))) else $error("address match");
  chk_reset_hold: assert property (
    soft_reset && $past(soft_reset) |-> !addr_match && !ten_power_off && !aneg_power_off)
    else $error("state not held");
  cover property ($fell(soft_reset));
  cover property (addr_match);
  cover property (ten_power_off);
endmodule // soft_reset_checker
bind phy_soft_reset_strap_latch soft_reset_checker u_chk (.*);
`default_nettype wire

// >>> tb/mgmt_station_model.sv
// management station: control byte writes and frame addresses
`timescale 1ns/10ps
`default_nettype none
module mgmt_station_model (
  input  wire logic       core_clk,        // clock
  input  wire logic       send_wr,         // request a byte write
  input  wire logic [4:0] target_addr,     // address put in frames
  output var logic        ctrl_hi_byte_wr, // write done pulse
  output var logic  [4:0] mgmt_frame_addr  // frame address
);
  initial ctrl_hi_byte_wr = 1'b0;
  initial mgmt_frame_addr = 5'h00;
  always @(posedge core_clk)
  begin
    ctrl_hi_byte_wr <= send_wr && !ctrl_hi_byte_wr;
    mgmt_frame_addr <= target_addr;
  end
endmodule // mgmt_station_model
`default_nettype wire

// >>> tb/phy_soft_reset_strap_latch_bench.sv
// bench for the soft reset sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module phy_soft_reset_strap_latch_bench;
  logic       core_clk = 0, reset_n = 0, send_wr = 0, speed_100 = 0, low_power_in = 0;
  logic [7:0] mode_pin_in = 8'h00, mode_cfg;
  logic [4:0] phy_address_strap = 5'h00, target_addr = 5'h00, mgmt_frame_addr;
  logic [4:0] phy_address, address_pin_out;
  logic       ctrl_hi_byte_wr, soft_reset, address_pin_oe, addr_match;
  logic       ten_power_off, aneg_power_off;
  int         bad_count = 0, n_compared = 0, n, k;
  initial forever #20 core_clk = ~core_clk;
  mgmt_station_model u_mgmt (.core_clk(core_clk), .send_wr(send_wr),
    .target_addr(target_addr), .ctrl_hi_byte_wr(ctrl_hi_byte_wr),
    .mgmt_frame_addr(mgmt_frame_addr));
  phy_soft_reset_strap_latch u_dut (.*);
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset(input logic [4:0] a, input logic [7:0] m, input logic s);
    @(posedge core_clk);
    phy_address_strap <= a; mode_pin_in <= m; speed_100 <= s; send_wr <= 1'b1;
    @(posedge core_clk) send_wr <= 1'b0;
    n = 0; k = 0;
    repeat (70) begin @(posedge core_clk); #1; n += (soft_reset === 1'b1);
      if (n > 0 && address_pin_oe !== 1'b1) k++; end
    `CHK(n, 13)
    `CHK(k, 43)
    `CHK(phy_address, a)
    `CHK(mode_cfg, m)
    `CHK(address_pin_out, {1'b0, s, 3'h0})
    $display("soft reset test done");
  endtask
  task automatic t_match;
    @(posedge core_clk) target_addr <= 5'h0a;
    repeat (3) @(posedge core_clk); #1;
    `CHK(addr_match, 1'b1)
    @(posedge core_clk) target_addr <= 5'h0b;
    repeat (3) @(posedge core_clk); #1;
    `CHK(addr_match, 1'b0)
    $display("address match test done");
  endtask
  task automatic t_power;
    @(posedge core_clk) low_power_in <= 1'b1;
    repeat (6) @(posedge core_clk); #1;
    `CHK({ten_power_off, aneg_power_off}, 2'h3)
    @(posedge core_clk) low_power_in <= 1'b0;
    repeat (6) @(posedge core_clk); #1;
    `CHK({ten_power_off, aneg_power_off}, 2'h0)
    $display("low power test done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset(5'h1f, 8'ha5, 1'b0);
    t_reset(5'h0a, 8'h5a, 1'b1);
    t_match();
    t_power();
    results();
  end
endmodule // phy_soft_reset_strap_latch_bench
`default_nettype wire
